// ===== rtl/cds_pkg.sv
package cds_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int INSTR_W   = 12;
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 5;
  localparam int PC_W      = 9;
  localparam int NUM_FILES = 32;

  // ------------------------------------------------------------------
  // Field positions inside the instruction word
  // ------------------------------------------------------------------
  localparam int OP6_MSB  = 11;
  localparam int OP6_LSB  = 6;
  localparam int OP3_MSB  = 11;
  localparam int OP3_LSB  = 9;
  localparam int DEST_BIT = 5;
  localparam int FADDR_MSB = 4;
  localparam int FADDR_LSB = 0;
  localparam int LIT_MSB  = 8;
  localparam int LIT_LSB  = 0;

  // ------------------------------------------------------------------
  // Opcode patterns
  // ------------------------------------------------------------------
  localparam logic [5:0] COMPLEMENT_REGISTER_OP = 6'h09;   // 0010 01
  localparam logic [5:0] DECREMENT_REGISTER_OP  = 6'h03;   // 0000 11
  localparam logic [5:0] DECREMENT_SKIP_ZERO_OP = 6'h0b;   // 0010 11
  localparam logic [2:0] UNCONDITIONAL_JUMP_OP  = 3'h5;    // 101
  localparam logic       DEST_ACC  = 1'b0;
  localparam logic       DEST_FILE = 1'b1;

  // ------------------------------------------------------------------
  // Reset values and constants
  // ------------------------------------------------------------------
  localparam logic [INSTR_W-1:0] NOP_WORD  = 12'h000;
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0]  FILE_RST  = 8'h00;
  localparam logic [DATA_W-1:0]  DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0]  DATA_ONE  = 8'h01;
  localparam logic               ZF_RST    = 1'b0;
  localparam logic [PC_W-1:0]    PC_RST    = 9'h000;
  localparam logic [PC_W-1:0]    PC_STEP   = 9'h001;

  // Execute slot: run the held word, or burn a no-operation
  typedef enum logic [0:0] {
    CDS_EXEC_ST  = 1'b0,
    CDS_FLUSH_ST = 1'b1
  } cds_state_t;

endpackage : cds_pkg

// ===== rtl/cds_op_if.sv
interface cds_op_if;
  import cds_pkg::*;

  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0]  operand;
  logic [DATA_W-1:0]  result;
  logic               to_file;
  logic               wr_en;
  logic               z_upd;
  logic               skip;
  logic               jump;
  logic [PC_W-1:0]    target;

  modport alu (
    input  instr,
    input  operand,
    output result,
    output to_file,
    output wr_en,
    output z_upd,
    output skip,
    output jump,
    output target
  );

  modport core (
    output instr,
    output operand,
    input  result,
    input  to_file,
    input  wr_en,
    input  z_upd,
    input  skip,
    input  jump,
    input  target
  );
endinterface : cds_op_if

// ===== rtl/cds_exec_alu.sv
module cds_exec_alu (
  // Decode request and answer
  cds_op_if.alu op
);
  import cds_pkg::*;

  // --------------------------------------------------------------
  // Decode and compute
  // --------------------------------------------------------------
  // Unknown words fall through as no-operation so the core stays safe
  always_comb begin
    op.result  = DATA_ZERO;
    op.to_file = op.instr[DEST_BIT];
    op.wr_en   = 1'b0;
    op.z_upd   = 1'b0;
    op.skip    = 1'b0;
    op.jump    = 1'b0;
    op.target  = op.instr[LIT_MSB:LIT_LSB];
    case (op.instr[OP6_MSB:OP6_LSB])
      COMPLEMENT_REGISTER_OP: begin
        op.result = ~op.operand;                         // RULE1
        op.wr_en  = 1'b1;                                // RULE3
        op.z_upd  = 1'b1;                                // RULE7
      end
      DECREMENT_REGISTER_OP: begin
        op.result = op.operand - DATA_ONE;               // RULE2
        op.wr_en  = 1'b1;                                // RULE3
        op.z_upd  = 1'b1;                                // RULE7
      end
      DECREMENT_SKIP_ZERO_OP: begin
        op.result = op.operand - DATA_ONE;               // RULE4
        op.wr_en  = 1'b1;                                // RULE5
        op.skip   = (op.result == DATA_ZERO);            // RULE6
      end
      default: begin
        op.jump = (op.instr[OP3_MSB:OP3_LSB] == UNCONDITIONAL_JUMP_OP); // RULE8
      end
    endcase
  end

endmodule : cds_exec_alu

// ===== rtl/cds_core.sv
// Notes on behaviour
// (RULE1) Complement opcode writes inverted register value to destination, updates zero.
// (RULE2) Decrement opcode writes register minus one to destination, updates zero.
// (RULE3) Complement/decrement: destination 0 goes to accumulator, 1 to register.
// (RULE4) Decrement-and-skip decrements and leaves every status flag untouched.
// (RULE5) Decrement-and-skip: destination 0 accumulator, 1 the addressed register.
// (RULE6) Zero result discards the fetched next word; a no-op fills its slot.
// (RULE7) Zero flag set when 8-bit result is zero, cleared otherwise, same cycle.
// (RULE8) Jump opcode loads 9-bit literal into program counter, takes two cycles.
module cds_core #(
  parameter int NUM_FILES = cds_pkg::NUM_FILES
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Instruction fetch
  input  wire logic [cds_pkg::INSTR_W-1:0]   instr_word,
  output logic      [cds_pkg::PC_W-1:0]      pc,
  // Core state
  output logic      [cds_pkg::DATA_W-1:0]    acc_value,
  output logic                               zero_flag,
  output logic                               slot_flushed,
  // Register inspection
  input  wire logic [cds_pkg::FADDR_W-1:0]   peek_addr,
  output logic      [cds_pkg::DATA_W-1:0]    peek_data
);
  import cds_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The register field is five bits; more files could never be reached
  if (NUM_FILES < 1 || NUM_FILES > (1 << FADDR_W)) begin : g_bad_files
    $error("NUM_FILES must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PC_W-1:0]    pc_ff;
  logic [PC_W-1:0]    nxt_pc;
  logic [INSTR_W-1:0] ir_ff;
  logic [INSTR_W-1:0] nxt_ir;
  cds_state_t         state_ff;
  cds_state_t         nxt_state;
  logic [DATA_W-1:0]  acc_ff;
  logic [DATA_W-1:0]  nxt_acc;
  logic               zf_ff;
  logic               nxt_zf;
  logic [DATA_W-1:0]  peek_ff;
  logic [DATA_W-1:0]  nxt_peek;
  logic [DATA_W-1:0]  files_ff  [NUM_FILES];
  logic [DATA_W-1:0]  nxt_files [NUM_FILES];

  // ----------------------------------------------------------------
  // Decode view of the execute slot
  // ----------------------------------------------------------------
  cds_op_if op ();

  logic [FADDR_W-1:0] ex_addr;
  logic               ex_addr_ok;
  logic               ex_cpl;
  logic               ex_dec;
  logic               ex_dsz;
  logic               ex_jmp;
  logic               ex_dest;
  logic [DATA_W-1:0]  ex_dec_val;

  // A flushed slot executes the no-operation word, never the fetched one
  assign op.instr = (state_ff == CDS_FLUSH_ST) ? NOP_WORD : ir_ff; // RULE6

  assign ex_addr    = op.instr[FADDR_MSB:FADDR_LSB];
  assign ex_addr_ok = (32'(ex_addr) < NUM_FILES);
  assign ex_dest    = op.instr[DEST_BIT];
  assign ex_cpl     = (op.instr[OP6_MSB:OP6_LSB] == COMPLEMENT_REGISTER_OP);
  assign ex_dec     = (op.instr[OP6_MSB:OP6_LSB] == DECREMENT_REGISTER_OP);
  assign ex_dsz     = (op.instr[OP6_MSB:OP6_LSB] == DECREMENT_SKIP_ZERO_OP);
  assign ex_jmp     = (op.instr[OP3_MSB:OP3_LSB] == UNCONDITIONAL_JUMP_OP);
  assign ex_dec_val = op.operand - DATA_ONE;

  // Files beyond the populated range read as zero
  assign op.operand = ex_addr_ok ? files_ff[ex_addr] : DATA_ZERO;

  cds_exec_alu u_alu (
    .op (op)
  );

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  // One word is fetched while the previous one executes, which is why a
  // taken skip or a jump costs a second cycle
  always_comb begin
    nxt_pc    = PC_W'(pc_ff + PC_STEP);
    nxt_ir    = instr_word;
    nxt_acc   = acc_ff;
    nxt_zf    = zf_ff;
    nxt_files = files_ff;
    nxt_state = CDS_EXEC_ST;
    nxt_peek  = (32'(peek_addr) < NUM_FILES) ? files_ff[peek_addr]
                                             : DATA_ZERO;
    if (op.wr_en) begin
      if (op.to_file == DEST_FILE) begin                   // RULE3 RULE5
        if (ex_addr_ok) begin
          nxt_files[ex_addr] = op.result;
        end
      end else begin
        nxt_acc = op.result;                              // RULE3 RULE5
      end
    end
    // Decrement-and-skip leaves z_upd low, so the flag holds
    if (op.z_upd) begin
      nxt_zf = (op.result == DATA_ZERO);                  // RULE7 RULE4
    end
    if (op.jump) begin
      nxt_pc = op.target;                                 // RULE8
    end
    if (op.skip || op.jump) begin
      nxt_state = CDS_FLUSH_ST;                           // RULE6 RULE8
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_ff    <= PC_RST;
      ir_ff    <= NOP_WORD;
      state_ff <= CDS_EXEC_ST;
      acc_ff   <= ACC_RST;
      zf_ff    <= ZF_RST;
      peek_ff  <= DATA_ZERO;
      for (int i = 0; i < NUM_FILES; i++) begin
        files_ff[i] <= FILE_RST;
      end
    end else begin
      pc_ff     <= nxt_pc;
      ir_ff     <= nxt_ir;
      state_ff  <= nxt_state;
      acc_ff    <= nxt_acc;
      zf_ff     <= nxt_zf;
      peek_ff   <= nxt_peek;
      files_ff  <= nxt_files;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pc           = pc_ff;
  assign acc_value    = acc_ff;
  assign zero_flag    = zf_ff;
  assign slot_flushed = (state_ff == CDS_FLUSH_ST);
  assign peek_data    = peek_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_cpl_result: assert property ( // RULE1
    ex_cpl && ex_dest == DEST_ACC |=> acc_ff == ~$past(op.operand)
  ) else $error("complement result not in accumulator");

  chk_dec_result: assert property ( // RULE2
    ex_dec && ex_dest == DEST_ACC |=> acc_ff == $past(ex_dec_val)
  ) else $error("decrement result not in accumulator");

  chk_dest_file: assert property ( // RULE3
    (ex_cpl || ex_dec) && ex_dest == DEST_FILE && ex_addr_ok
      |=> $stable(acc_ff) && files_ff[$past(ex_addr)] == $past(op.result)
  ) else $error("file destination not honoured");

  chk_dsz_flags: assert property ( // RULE4
    ex_dsz |=> $stable(zf_ff)
  ) else $error("decrement-and-skip touched the zero flag");

  chk_dsz_dest: assert property ( // RULE5
    ex_dsz && ex_dest == DEST_ACC |=> acc_ff == $past(ex_dec_val)
  ) else $error("decrement-and-skip result lost");

  chk_skip_slot: assert property ( // RULE6
    ex_dsz && ex_dec_val == DATA_ZERO
      |=> slot_flushed && op.instr == NOP_WORD ##1 !slot_flushed
  ) else $error("zero result did not discard the next word");

  chk_no_skip: assert property ( // RULE6
    ex_dsz && ex_dec_val != DATA_ZERO |=> !slot_flushed
  ) else $error("nonzero result discarded a word");

  chk_zero_flag: assert property ( // RULE7
    ex_cpl || ex_dec |=> zf_ff == ($past(op.result) == DATA_ZERO)
  ) else $error("zero flag wrong after update");

  chk_jump_pc: assert property ( // RULE8
    ex_jmp |=> pc_ff == $past(ir_ff[LIT_MSB:LIT_LSB]) && slot_flushed
  ) else $error("jump did not load the literal");

endmodule : cds_core

// ===== tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cds_pkg::*;

  // ----------------------------------------------------------------
  // Signals, program memory and bench bookkeeping
  // ----------------------------------------------------------------
  // Clock starts low here so that only the toggling process drives it
  logic               clk = 1'b0;
  logic               rst;
  logic [INSTR_W-1:0] instr_word;
  logic [PC_W-1:0]    pc;
  logic [DATA_W-1:0]  acc_value;
  logic               zero_flag;
  logic               slot_flushed;
  logic [FADDR_W-1:0] peek_addr;
  logic [DATA_W-1:0]  peek_data;
  logic [INSTR_W-1:0] prog [0:511];
  int                 num_errors  = 0;
  int                 checks_done = 0;
  int                 cycles      = 0;
  int                 seed        = 48527;

  // Reference state, stepped once per edge like the core
  logic [PC_W-1:0]    m_pc;
  logic [DATA_W-1:0]  m_acc;
  logic [DATA_W-1:0]  m_peek;
  logic               m_z;
  logic               m_flush;
  logic [INSTR_W-1:0] m_fetch;
  logic [DATA_W-1:0]  m_file [0:31];

  cds_core #(.NUM_FILES(32)) cds_core_inst (
    .clk          (clk),
    .rst          (rst),
    .instr_word   (instr_word),
    .pc           (pc),
    .acc_value    (acc_value),
    .zero_flag    (zero_flag),
    .slot_flushed (slot_flushed),
    .peek_addr    (peek_addr),
    .peek_data    (peek_data)
  );

  // Program memory answers in the same cycle as the fetch address
  assign instr_word = prog[pc];

  // Clock
  always #5 clk = ~clk;

  // Random inspection address keeps every file visible over time
  always @(posedge clk) begin
    peek_addr <= 5'($random(seed));
  end

  // ----------------------------------------------------------------
  // Reference model of fetch and execute
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin : model
    logic [INSTR_W-1:0] w;
    logic [DATA_W-1:0]  v;
    logic [DATA_W-1:0]  r;
    logic [PC_W-1:0]    npc;
    logic               nfl;
    if (rst) begin
      m_pc    = PC_RST;
      m_acc   = ACC_RST;
      m_z     = ZF_RST;
      m_flush = 1'b0;
      m_fetch = NOP_WORD;
      m_peek  = FILE_RST;
      foreach (m_file[i]) m_file[i] = FILE_RST;
    end else begin
      w      = m_fetch;
      npc    = m_pc + PC_STEP;
      nfl    = 1'b0;
      m_peek = m_file[peek_addr];
      v      = m_file[w[FADDR_MSB:FADDR_LSB]];
      r      = (w[11:6] == COMPLEMENT_REGISTER_OP) ? ~v : v - DATA_ONE;
      // A discarded word never executes, whatever it holds
      if (!m_flush) begin
        if (w[11:6] inside {COMPLEMENT_REGISTER_OP, DECREMENT_REGISTER_OP,
                            DECREMENT_SKIP_ZERO_OP}) begin
          if (w[DEST_BIT] == DEST_FILE) m_file[w[4:0]] = r;
          else m_acc = r;
          if (w[11:6] == DECREMENT_SKIP_ZERO_OP) nfl = (r == DATA_ZERO);
          else m_z = (r == DATA_ZERO);
        end else if (w[11:9] == UNCONDITIONAL_JUMP_OP) begin
          npc = w[LIT_MSB:LIT_LSB];
          nfl = 1'b1;
        end
      end
      m_fetch = prog[m_pc];
      m_pc    = npc;
      m_flush = nfl;
    end
  end

  // ----------------------------------------------------------------
  // Checks and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Outputs are settled by the falling edge
  always @(negedge clk) begin
    if (!rst) begin
      chk({7'h00, pc}, {7'h00, m_pc});
      chk({8'h00, acc_value}, {8'h00, m_acc});
      chk({15'h0, zero_flag}, {15'h0, m_z});
      chk({15'h0, slot_flushed}, {15'h0, m_flush});
      chk({8'h00, peek_data}, {8'h00, m_peek});
    end
  end

  // Hang guard: both tests together need well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      report_and_stop();
    end
  end

  function automatic logic [11:0] op(logic [5:0] c, logic d, logic [4:0] f);
    return {c, d, f};
  endfunction : op

  function automatic logic [11:0] jmp(logic [8:0] k);
    return {UNCONDITIONAL_JUMP_OP, k};
  endfunction : jmp

  // Reset for two cycles, then let the loaded program run
  task automatic run_prog(input string name, input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (n) @(posedge clk);
    $display("test %s done", name);
  endtask : run_prog

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    rst       = 1'b1;
    foreach (prog[i]) prog[i] = NOP_WORD;
    // Walk a file down to one, then skip on zero into both destinations
    prog[0]  = op(DECREMENT_REGISTER_OP, 1'b1, 5'h04);
    prog[1]  = op(DECREMENT_REGISTER_OP, 1'b1, 5'h04);
    prog[2]  = op(COMPLEMENT_REGISTER_OP, 1'b1, 5'h04);
    prog[3]  = op(DECREMENT_SKIP_ZERO_OP, 1'b0, 5'h04);
    prog[4]  = jmp(9'h000);
    prog[5]  = op(DECREMENT_SKIP_ZERO_OP, 1'b1, 5'h04);
    prog[6]  = op(COMPLEMENT_REGISTER_OP, 1'b1, 5'h04);
    prog[7]  = op(DECREMENT_SKIP_ZERO_OP, 1'b1, 5'h04);
    prog[8]  = op(COMPLEMENT_REGISTER_OP, 1'b0, 5'h04);
    prog[9]  = op(DECREMENT_SKIP_ZERO_OP, 1'b1, 5'h1f);
    prog[10] = jmp(9'h00c);
    prog[11] = jmp(9'h000);
    prog[12] = op(DECREMENT_REGISTER_OP, 1'b0, 5'h1f);
    prog[13] = 12'hfff;
    prog[14] = op(COMPLEMENT_REGISTER_OP, 1'b1, 5'h00);
    prog[15] = jmp(9'h00f);
    run_prog("directed", 40);
    // Reload off the fetch edge so core and model see the same words
    @(negedge clk);
    // Random mix of all four operations plus unknown words
    for (int i = 0; i < 256; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'd0, 3'd1: prog[i] = op(COMPLEMENT_REGISTER_OP, r[21], r[20:16]);
        3'd2, 3'd3: prog[i] = op(DECREMENT_REGISTER_OP, r[21], r[20:16]);
        3'd4, 3'd5: prog[i] = op(DECREMENT_SKIP_ZERO_OP, r[21], r[20:16]);
        3'd6:       prog[i] = jmp({1'b0, r[15:8]});
        default:    prog[i] = r[31:20];
      endcase
    end
    run_prog("random", 3000);
    report_and_stop();
  end
endmodule : tb_top
